// *** pssi_status_irq.sv ***
`timescale 1ns/1ps
module pssi_status_irq (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // phy state, from the pins of the link logic
  input  wire logic        link_up,
  input  wire logic        speed_10,
  input  wire logic        full_duplex,
  input  wire logic        loopback_on,
  input  wire logic        autoneg_done,
  input  wire logic        jabber_seen,
  input  wire logic        remote_fault_seen,
  input  wire logic        energy_detect,
  input  wire logic        link_quality_evt,
  input  wire logic        false_carrier_half,
  input  wire logic        rx_error_half,
  // shared power-down / interrupt pin
  input  wire logic        powerdown_or_irq_pin_in,
  output logic             powerdown_or_irq_pin_out,
  output logic             powerdown_or_irq_pin_oe,
  output logic             powerdown_req,
  // system interrupt
  output logic             irq
);
  // three-stage synchroniser for every outside level
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] sync1, sync2, sync3, stable;
  wire  [NSYNC-1:0] raw_in = {powerdown_or_irq_pin_in, rx_error_half, false_carrier_half, link_quality_evt,
                              energy_detect, remote_fault_seen, jabber_seen, autoneg_done, loopback_on,
                              full_duplex, speed_10};
  // link_up rides separately so bit indices stay readable
  logic link_s1, link_s2, link_s3, link_st;

  // sync chain; stable moves only when stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1   <= '0;
      sync2   <= '0;
      sync3   <= '0;
      stable  <= '0;
      link_s1 <= 1'b0;
      link_s2 <= 1'b0;
      link_s3 <= 1'b0;
      link_st <= 1'b0;
    end else begin
      sync1   <= raw_in;
      sync2   <= sync1;
      sync3   <= sync2;
      // a bit whose stages disagree keeps its old value, so a metastable
      // settle never shows up as a short glitch on the status bits
      stable  <= (stable & (sync2 ^ sync3)) | (sync2 & ~(sync2 ^ sync3));
      link_s1 <= link_up;
      link_s2 <= link_s1;
      link_s3 <= link_s2;
      if (link_s2 == link_s3) link_st <= link_s3;
    end
  end

  wire s_speed10 = stable[0];
  wire s_duplex  = stable[1];
  wire s_loop    = stable[2];
  wire s_andone  = stable[3];
  wire s_jabber  = stable[4];
  wire s_rfault  = stable[5];
  wire s_energy  = stable[6];
  wire s_lq      = stable[7];
  wire s_fhf     = stable[8];
  wire s_rhf     = stable[9];
  wire s_pin     = stable[10];

  // previous values give change events
  logic prev_link, prev_speed, prev_dup, prev_an, prev_ed, prev_lq, prev_fhf, prev_rhf;
  always_ff @(posedge clk) begin
    if (srst) begin
      {prev_link, prev_speed, prev_dup, prev_an, prev_ed, prev_lq, prev_fhf, prev_rhf} <= 8'h00;
    end else begin
      {prev_link, prev_speed, prev_dup, prev_an, prev_ed, prev_lq, prev_fhf, prev_rhf} <=
        {link_st, s_speed10, s_duplex, s_andone, s_energy, s_lq, s_fhf, s_rhf};
    end
  end

  // event strobes; half-full, completion and link quality count on rising edge only
  logic [7:0] ev_now;
  always_comb begin
    ev_now = 8'h00;
    ev_now[pssi_pkg::EV_LINK] = link_st ^ prev_link;
    ev_now[pssi_pkg::EV_SPD]  = s_speed10 ^ prev_speed;
    ev_now[pssi_pkg::EV_DUP]  = s_duplex ^ prev_dup;
    ev_now[pssi_pkg::EV_ANC]  = s_andone & ~prev_an;
    ev_now[pssi_pkg::EV_ED]   = s_energy ^ prev_ed;
    ev_now[pssi_pkg::EV_LQ]   = s_lq & ~prev_lq;
    ev_now[pssi_pkg::EV_FHF]  = s_fhf & ~prev_fhf;
    ev_now[pssi_pkg::EV_RHF]  = s_rhf & ~prev_rhf;
  end

  // ---------------- bus slave ----------------
  logic [7:0]  aw_addr, ar_addr;    // captured write address; ar_addr is never loaded
  logic        aw_have, w_have;     // halves of a write held
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_write = aw_have & w_have;
  wire do_read  = s_axi_arvalid & s_axi_arready;

  // write address decode
  wire wr_ctrl  = do_write && (aw_addr == pssi_pkg::ADDR_INT_CONTROL);
  wire wr_event = do_write && (aw_addr == pssi_pkg::ADDR_EVENT_STATUS);
  wire wr_irqs  = do_write && (aw_addr == pssi_pkg::ADDR_IRQ_STATUS);
  wire wr_mask  = do_write && (aw_addr == pssi_pkg::ADDR_IRQ_MASK);
  wire wr_known = wr_ctrl | wr_event | wr_irqs | wr_mask
                | (aw_addr == pssi_pkg::ADDR_STATUS_SUMMARY) | (aw_addr == pssi_pkg::ADDR_BASIC_STATUS);
  // read address decode; reads have side effects so only on acceptance
  wire rd_basic = do_read && (s_axi_araddr == pssi_pkg::ADDR_BASIC_STATUS);
  wire rd_event = do_read && (s_axi_araddr == pssi_pkg::ADDR_EVENT_STATUS);

  // capture write halves in either order
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else if (do_write) begin
      // both halves consumed; readies stay low until bvalid is taken
      aw_have <= 1'b0;
      w_have  <= 1'b0;
    end else begin
      // each half is held here until its partner arrives
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pssi_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? pssi_pkg::RESP_OKAY : pssi_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- control and event registers ----------------
  logic [2:0] int_ctrl;   // test, global enable, output enable
  logic [7:0] ev_enable;  // per-event enables
  pssi_ev_if ev ();
  assign ev.event_pulse   = ev_now;
  assign ev.clear_on_read = rd_event;

  pssi_event_latch u_latch (
    .clk  (clk),
    .srst (srst),
    .ev   (ev.latch)
  );

  // only low byte lane carries writable bits; upper bits never stored
  always_ff @(posedge clk) begin
    if (srst) begin
      int_ctrl  <= pssi_pkg::IC_RESET;
      ev_enable <= 8'h00;
    end else begin
      if (wr_ctrl && w_strb[0]) int_ctrl <= w_data[2:0];
      if (wr_event && w_strb[0]) ev_enable <= w_data[7:0];
    end
  end

  // remote fault holds until basic status read; new fault wins the clear
  logic rfault_latch;
  always_ff @(posedge clk) begin
    if (srst) rfault_latch <= 1'b0;
    else if (s_rfault) rfault_latch <= 1'b1;
    else if (rd_basic) rfault_latch <= 1'b0;
  end

  // interrupt source combination
  wire ev_irq   = int_ctrl[pssi_pkg::IC_EN] & |(ev.pending & ev_enable);
  wire phy_int  = int_ctrl[pssi_pkg::IC_TEST] | ev_irq;

  // status summary value; plain copies so summary reads clear nothing
  logic [15:0] summary;
  always_comb begin
    summary = 16'h0000;
    summary[pssi_pkg::SS_LINK]    = link_st;
    summary[pssi_pkg::SS_SPEED10] = s_speed10;
    summary[pssi_pkg::SS_DUPLEX]  = s_duplex;
    summary[pssi_pkg::SS_LOOP]    = s_loop;
    summary[pssi_pkg::SS_ANDONE]  = s_andone;
    summary[pssi_pkg::SS_JABBER]  = s_jabber;
    summary[pssi_pkg::SS_RFAULT]  = rfault_latch;
    summary[pssi_pkg::SS_IRQPEND] = phy_int;
  end

  // basic status view; jabber meaningful in 10 Mb/s only
  wire [15:0] basic = {11'h000, rfault_latch, 1'b0, link_st, s_jabber & s_speed10, 1'b0};

  // ---------------- wrapper interrupt ----------------
  logic [1:0] irq_status, irq_mask;
  logic       prev_phy_int;
  wire  [1:0] irq_set = {s_rfault & ~rfault_latch, phy_int & ~prev_phy_int};
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status   <= 2'h0;
      irq_mask     <= 2'h0;
      prev_phy_int <= 1'b0;
    end else begin
      prev_phy_int <= phy_int;
      // set wins over write-one-to-clear
      irq_status <= (irq_status & ~((wr_irqs && w_strb[0]) ? w_data[1:0] : 2'h0)) | irq_set;
      if (wr_mask && w_strb[0]) irq_mask <= w_data[1:0];
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ---------------- read data ----------------
  wire [15:0] rd_val =
      (s_axi_araddr == pssi_pkg::ADDR_STATUS_SUMMARY) ? summary :
      (s_axi_araddr == pssi_pkg::ADDR_INT_CONTROL)    ? {13'h0000, int_ctrl} :
      (s_axi_araddr == pssi_pkg::ADDR_EVENT_STATUS)   ? {ev.pending, ev_enable} :
      (s_axi_araddr == pssi_pkg::ADDR_BASIC_STATUS)   ? basic :
      (s_axi_araddr == pssi_pkg::ADDR_IRQ_STATUS)     ? {14'h0000, irq_status} :
      (s_axi_araddr == pssi_pkg::ADDR_IRQ_MASK)       ? {14'h0000, irq_mask} : 16'h0000;
  wire rd_known = (s_axi_araddr == pssi_pkg::ADDR_STATUS_SUMMARY) | (s_axi_araddr == pssi_pkg::ADDR_INT_CONTROL)
                | (s_axi_araddr == pssi_pkg::ADDR_EVENT_STATUS) | (s_axi_araddr == pssi_pkg::ADDR_BASIC_STATUS)
                | (s_axi_araddr == pssi_pkg::ADDR_IRQ_STATUS) | (s_axi_araddr == pssi_pkg::ADDR_IRQ_MASK);

  // read response, data registered at acceptance
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= pssi_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_known ? pssi_pkg::RESP_OKAY : pssi_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- shared pin ----------------
  // registered so the pin never glitches on decode
  always_ff @(posedge clk) begin
    if (srst) begin
      // pin comes up as an input, so power-down control works from reset
      powerdown_or_irq_pin_oe  <= 1'b0;
      powerdown_or_irq_pin_out <= 1'b0;
      powerdown_req            <= 1'b0;
    end else begin
      powerdown_or_irq_pin_oe  <= int_ctrl[pssi_pkg::IC_OE];
      powerdown_or_irq_pin_out <= phy_int;
      powerdown_req <= ~int_ctrl[pssi_pkg::IC_OE] & s_pin;
    end
  end
endmodule

// *** pssi_pkg.sv ***
package pssi_pkg;
  // register byte addresses on the lite bus
  localparam logic [7:0] ADDR_STATUS_SUMMARY = 8'h00;
  localparam logic [7:0] ADDR_INT_CONTROL    = 8'h04;
  localparam logic [7:0] ADDR_EVENT_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_BASIC_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h14;
  // status summary bit positions
  localparam int SS_LINK    = 0;
  localparam int SS_SPEED10 = 1;
  localparam int SS_DUPLEX  = 2;
  localparam int SS_LOOP    = 3;
  localparam int SS_ANDONE  = 4;
  localparam int SS_JABBER  = 5;
  localparam int SS_RFAULT  = 6;
  localparam int SS_IRQPEND = 7;
  // interrupt control bit positions
  localparam int IC_OE   = 0;
  localparam int IC_EN   = 1;
  localparam int IC_TEST = 2;
  localparam logic [2:0] IC_RESET = 3'h0;
  // event index inside the event register (pending at +8, enable at +0)
  localparam int EV_COUNT   = 8;
  localparam int EV_PEND_LO = 8;
  localparam int EV_RHF     = 0;
  localparam int EV_FHF     = 1;
  localparam int EV_ANC     = 2;
  localparam int EV_DUP     = 3;
  localparam int EV_SPD     = 4;
  localparam int EV_LINK    = 5;
  localparam int EV_ED      = 6;
  localparam int EV_LQ      = 7;
  // basic status bit positions (remote fault is held here, jabber is a live level)
  localparam int BS_JABBER = 1;
  localparam int BS_LINK   = 2;
  localparam int BS_RFAULT = 4;
  // wrapper interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_RFAULT = 1;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** pssi_if.sv ***
`timescale 1ns/1ps
// event strobes and the read clear handed to the event latch, pending bits back
interface pssi_ev_if;
  logic [7:0] event_pulse;   // one-cycle event strobes
  logic       clear_on_read; // event register is being read
  logic [7:0] pending;       // latched pending bits
  modport latch (input event_pulse, input clear_on_read, output pending);
  modport ctrl  (output event_pulse, output clear_on_read, input pending);
endinterface

// *** pssi_event_latch.sv ***
`timescale 1ns/1ps
// sticky pending bits for the event register
module pssi_event_latch (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // event side
  pssi_ev_if.latch ev
);
  logic [7:0] pending; // one sticky bit per event

  // latch always, even with the enable clear; a new event beats a read clear
  always_ff @(posedge clk) begin
    if (srst) begin
      pending <= 8'h00;
    end else if (ev.clear_on_read) begin
      pending <= ev.event_pulse;
    end else begin
      pending <= pending | ev.event_pulse;
    end
  end

  assign ev.pending = pending;
endmodule

// *** pssi_status_irq_asserts.sv ***
`timescale 1ns/1ps
// watches the lite bus and the shared pin of the block
module pssi_status_irq_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // lite bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // shared pin
  input wire logic        powerdown_or_irq_pin_in,
  input wire logic        powerdown_or_irq_pin_out,
  input wire logic        powerdown_or_irq_pin_oe,
  input wire logic        powerdown_req
);
  logic [7:0]  wa;  // last write address taken
  logic [7:0]  ra;  // last read address taken
  logic [31:0] wd;  // last write data taken
  logic        bad; // read address outside the map
  // no reset: every use waits for a handshake first
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  assign bad = (ra > 8'h14) || (ra[1:0] != 2'h0);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_ctrl_upper: assert property (s_axi_rvalid && ra == pssi_pkg::ADDR_INT_CONTROL
    |-> s_axi_rdata[31:3] == 29'h0) else $error("control upper bits set");
  a_resp_map: assert property (s_axi_rvalid |-> s_axi_rresp == (bad ? pssi_pkg::RESP_SLVERR : pssi_pkg::RESP_OKAY))
    else $error("wrong read response");
  a_oe_follow: assert property ($rose(s_axi_bvalid) && wa == pssi_pkg::ADDR_INT_CONTROL
    |-> ##2 powerdown_or_irq_pin_oe == wd[pssi_pkg::IC_OE]) else $error("pin direction wrong");
  a_test_force: assert property ($rose(s_axi_bvalid) && wa == pssi_pkg::ADDR_INT_CONTROL && wd[2:0] == 3'h7
    |-> ##[1:4] powerdown_or_irq_pin_out [*4]) else $error("test interrupt missing");
  a_test_stop: assert property ($rose(s_axi_bvalid) && wa == pssi_pkg::ADDR_INT_CONTROL && wd[2:0] == 3'h1
    |-> ##[1:4] !powerdown_or_irq_pin_out) else $error("interrupt not stopped");
  a_req_follow: assert property ((!powerdown_or_irq_pin_oe && $stable(powerdown_or_irq_pin_in)) [*6]
    |-> powerdown_req == powerdown_or_irq_pin_in) else $error("power-down request wrong");
  c_pin_irq: cover property (powerdown_or_irq_pin_oe && powerdown_or_irq_pin_out);
  c_bad_read: cover property (s_axi_rvalid && bad);
  c_write: cover property ($rose(s_axi_bvalid));
endmodule
bind pssi_status_irq pssi_status_irq_chk i_chk (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .powerdown_or_irq_pin_in,
  .powerdown_or_irq_pin_out, .powerdown_or_irq_pin_oe, .powerdown_req);

// *** pssi_host_model.sv ***
`timescale 1ns/1ps
// management host: one lite write or read at a time, no fixed latency assumed
module pssi_host_model (
  // clock
  input wire logic         clk,
  // requests
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  output logic             s_axi_rready,
  // answers
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid
);
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
  initial {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = 52'h0;
  // address and data go out together; each is dropped on its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // bready stays up until the answer is seen
    while (!s_axi_bvalid) @(posedge clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module tb_top;
  logic clk, srst, pin_in, pin_out, pin_oe, pd_req, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [10:0] ph; // phy state levels, one bit per status input
  int n_fail, comparisons, cycles;
  pssi_status_irq i_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_up(ph[0]), .speed_10(ph[1]),
    .full_duplex(ph[2]), .loopback_on(ph[3]), .autoneg_done(ph[4]), .jabber_seen(ph[5]),
    .remote_fault_seen(ph[6]), .energy_detect(ph[7]), .link_quality_evt(ph[8]), .false_carrier_half(ph[9]),
    .rx_error_half(ph[10]), .powerdown_or_irq_pin_in(pin_in), .powerdown_or_irq_pin_out(pin_out),
    .powerdown_or_irq_pin_oe(pin_oe), .powerdown_req(pd_req), .irq);
  pssi_host_model i_host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rready, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // every event kind latches with its enable off; the event read clears it
  task automatic t_events;
    int src [8] = '{10, 9, 4, 2, 1, 0, 7, 8};
    for (int k = 0; k < 8; k++) begin
      ph[src[k]] <= 1'b1;
      cyc(8);
      i_host.rd(pssi_pkg::ADDR_EVENT_STATUS, d, r);
      `CHK(d, 32'h1 << (pssi_pkg::EV_PEND_LO + k))
    end
  endtask
  // summary copies survive reads; host trusts speed and duplex as link and an are up
  task t_status;
    ph[3] <= 1'b1;
    ph[5] <= 1'b1;
    cyc(8);
    repeat (2) begin
      i_host.rd(pssi_pkg::ADDR_STATUS_SUMMARY, d, r);
      `CHK(d[7:0], 8'h3F)
    end
    ph[2:1] <= 2'h0;
    cyc(8);
    i_host.rd(pssi_pkg::ADDR_STATUS_SUMMARY, d, r);
    `CHK(d[2:1], 2'h0)
    i_host.rd(pssi_pkg::ADDR_EVENT_STATUS, d, r);
  endtask
  // remote fault holds until the basic status read
  task t_rfault;
    ph[6] <= 1'b1;
    cyc(6);
    ph[6] <= 1'b0;
    cyc(6);
    repeat (2) begin
      i_host.rd(pssi_pkg::ADDR_STATUS_SUMMARY, d, r);
      `CHK(d[6], 1'b1)
    end
    i_host.rd(pssi_pkg::ADDR_BASIC_STATUS, d, r);
    `CHK(d[pssi_pkg::BS_RFAULT], 1'b1)
    i_host.rd(pssi_pkg::ADDR_STATUS_SUMMARY, d, r);
    `CHK(d[6], 1'b0)
  endtask
  // control register, test interrupt, pin direction, unmapped read
  task t_ctrl;
    i_host.rd(pssi_pkg::ADDR_INT_CONTROL, d, r);
    `CHK(d, 32'h0)
    i_host.rd(8'h18, d, r);
    `CHK({r, d}, {pssi_pkg::RESP_SLVERR, 32'h0})
    i_host.wr(pssi_pkg::ADDR_INT_CONTROL, 32'hFFFFFFFF, r);
    `CHK(r, pssi_pkg::RESP_OKAY)
    i_host.wr(8'h18, 32'h0, r);
    `CHK(r, pssi_pkg::RESP_SLVERR)
    i_host.rd(pssi_pkg::ADDR_INT_CONTROL, d, r);
    `CHK(d, 32'h7)
    cyc(6);
    `CHK({pin_oe, pin_out}, 2'h3)
    i_host.wr(pssi_pkg::ADDR_INT_CONTROL, 32'h1, r);
    cyc(4);
    `CHK(pin_out, 1'b0)
    i_host.wr(pssi_pkg::ADDR_INT_CONTROL, 32'h0, r);
    pin_in <= 1'b1;
    cyc(8);
    `CHK({pin_oe, pd_req}, 2'h1)
    pin_in <= 1'b0;
  endtask
  // event interrupt needs both enables; then status, mask and clear of irq
  task t_irq;
    i_host.wr(pssi_pkg::ADDR_EVENT_STATUS, 32'h20, r);
    i_host.wr(pssi_pkg::ADDR_INT_CONTROL, 32'h1, r);
    ph[0] <= 1'b0;
    cyc(8);
    `CHK(pin_out, 1'b0)
    i_host.wr(pssi_pkg::ADDR_INT_CONTROL, 32'h3, r);
    cyc(4);
    `CHK(pin_out, 1'b1)
    i_host.rd(pssi_pkg::ADDR_STATUS_SUMMARY, d, r);
    `CHK(d[7], 1'b1)
    i_host.rd(pssi_pkg::ADDR_EVENT_STATUS, d, r);
    `CHK(d[15:0], 16'h2020)
    cyc(4);
    `CHK(pin_out, 1'b0)
    i_host.rd(pssi_pkg::ADDR_IRQ_STATUS, d, r);
    `CHK({irq, d[1:0]}, 3'h3)
    i_host.wr(pssi_pkg::ADDR_IRQ_MASK, 32'h1, r);
    cyc(2);
    `CHK(irq, 1'b1)
    i_host.wr(pssi_pkg::ADDR_IRQ_STATUS, 32'h1, r);
    cyc(2);
    `CHK(irq, 1'b0)
  endtask
  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    {srst, ph, pin_in} = 13'h1000;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_events;
    t_status;
    t_rfault;
    t_ctrl;
    t_irq;
    test_done;
  end
endmodule
